/* File: logic/lpdcs_consts.svh */
// Constants for the low-power command watcher
`ifndef LPDCS_CONSTS_SVH
`define LPDCS_CONSTS_SVH
`define LPDCS_CPDED_CYCLES 2
`define LPDCS_STABLE_CYCLES 2
`define LPDCS_XP_CYCLES 3
`define LPDCS_IDLE_TIMEOUT 16
`endif

/* File: logic/lpdcs_pkg.sv */
// Types for the low-power command watcher
`default_nettype none
package lpdcs_pkg;
  typedef enum logic [4:0] {
    LPDCS_ACTIVE = 5'b00001,
    LPDCS_DPD_ENTRY = 5'b00010,
    LPDCS_DPD = 5'b00100,
    LPDCS_UNINIT = 5'b01000,
    LPDCS_WAKE = 5'b10000
  } lpdcs_state_e;
endpackage : lpdcs_pkg
`default_nettype wire

/* File: logic/lpdcs_sync.sv */
// Two-flop synchroniser for one pin
`timescale 1ns/1ns
`default_nettype none
module lpdcs_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Pin and synchronised level
  input wire logic pin_in,
  output logic level_out
);
  logic meta_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_q <= pin_in;
      level_out <= meta_q;
    end
  end
endmodule : lpdcs_sync
`default_nettype wire

/* File: logic/lpdcs_top.sv */
// Deep power-down, clock change and NOP command watcher
`timescale 1ns/1ns
`default_nettype none
`include "lpdcs_consts.svh"
// How it works
// - DPD entry: CKE sampled low, CS low, CA0 high, CA1 high, CA2 low.
// - Array contents are discarded on DPD entry.
// - In DPD, inputs except CKE, outputs and internal power are off.
// - Command receivers switch off only after tCPDED elapses.
// - DPD exits when CKE sampled high at a rising link clock edge.
// - Ready after CKE-high clock restart: 2 clocks plus exit latency.
// - NOP is CS high, or CS low with CA0..CA2 high.
// - NOP valid only when CKE equal this cycle and the previous.
// - A NOP never aborts an operation in progress.
module lpdcs_top
  import lpdcs_pkg::*;
#(
  parameter int IDLE_TIMEOUT = `LPDCS_IDLE_TIMEOUT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Command pins from the controller
  input wire logic ck_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [2:0] ca_in,
  // Initialization done strobe from the init sequencer
  input wire logic init_done_in,
  // Status
  output logic in_dpd_out,
  output logic rx_enable_out,
  output logic core_power_out,
  output logic data_valid_out,
  output logic ready_out,
  output logic nop_out,
  output logic clock_stopped_out
);
  logic ck_s, cke_s, cs_n_s, ca0_s, ca1_s, ca2_s;
  logic ck_prev_q, cke_prev_q;
  logic [1:0] cpded_q;
  logic [1:0] stable_q;
  logic [3:0] wake_q;
  logic [7:0] idle_q;
  lpdcs_state_e state_q, state_d;

  lpdcs_sync u_ck (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(ck_in),
    .level_out(ck_s)
  );
  lpdcs_sync u_cke (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(cke_in),
    .level_out(cke_s)
  );
  lpdcs_sync u_cs (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(cs_n_in),
    .level_out(cs_n_s)
  );
  lpdcs_sync u_ca0 (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(ca_in[0]),
    .level_out(ca0_s)
  );
  lpdcs_sync u_ca1 (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(ca_in[1]),
    .level_out(ca1_s)
  );
  lpdcs_sync u_ca2 (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(ca_in[2]),
    .level_out(ca2_s)
  );

  // Pins only mean something at a rising link clock edge
  wire ck_rise = ck_s & ~ck_prev_q;
  wire dpd_cmd = ~cke_s & cke_prev_q & ~cs_n_s & ca0_s & ca1_s & ~ca2_s;
  wire nop_enc = cs_n_s | (ca0_s & ca1_s & ca2_s);
  wire nop_valid = nop_enc & (cke_s == cke_prev_q);
  // exit on CKE high at an edge
  wire dpd_exit = cke_s & ck_rise;
  wire idle_full = (idle_q == IDLE_TIMEOUT[7:0]);
  wire stable_ok = (stable_q == 2'(`LPDCS_STABLE_CYCLES));
  wire wake_done = (wake_q == 4'(`LPDCS_STABLE_CYCLES + `LPDCS_XP_CYCLES));

  always_comb begin
    state_d = state_q;
    case (state_q)
      LPDCS_ACTIVE: begin
        if (ck_rise && dpd_cmd) begin
          state_d = LPDCS_DPD_ENTRY;
        // Any stop, CKE high or low, waits out the exit latency
        end else if (idle_full) begin
          state_d = LPDCS_WAKE;
        end
      end
      LPDCS_DPD_ENTRY: begin
        if (ck_rise && cpded_q == 2'(`LPDCS_CPDED_CYCLES - 1)) begin
          state_d = LPDCS_DPD;
        end
      end
      LPDCS_DPD: begin
        if (dpd_exit) begin
          state_d = LPDCS_UNINIT;
        end
      end
      LPDCS_UNINIT: begin
        // normal use only after init completes
        if (init_done_in) begin
          state_d = LPDCS_ACTIVE;
        end
      end
      LPDCS_WAKE: begin
        if (wake_done && cke_s) begin
          state_d = LPDCS_ACTIVE;
        end
      end
      default: state_d = LPDCS_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ck_prev_q <= 1'b0;
      cke_prev_q <= 1'b0;
      state_q <= LPDCS_UNINIT;
    end else begin
      ck_prev_q <= ck_s;
      if (ck_rise) begin
        cke_prev_q <= cke_s;
      end
      state_q <= state_d;
    end
  end

  // Counts link edges; a stopped clock stops them
  always_ff @(posedge clk_in) begin
    if (reset_in || state_q != LPDCS_DPD_ENTRY) begin
      cpded_q <= 2'h0;
    end else if (ck_rise) begin
      cpded_q <= cpded_q + 2'h1;
    end
  end

  // Idle count detects a stopped clock in local cycles
  always_ff @(posedge clk_in) begin
    if (reset_in || ck_s != ck_prev_q) begin
      idle_q <= 8'h00;
    end else if (!idle_full) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  // stable edge count since the clock restarted
  always_ff @(posedge clk_in) begin
    if (reset_in || idle_full) begin
      stable_q <= 2'h0;
    end else if (ck_rise && !stable_ok) begin
      stable_q <= stable_q + 2'h1;
    end
  end

  // wake latency counted in link edges after restart
  always_ff @(posedge clk_in) begin
    if (reset_in || state_q != LPDCS_WAKE || idle_full) begin
      wake_q <= 4'h0;
    end else if (ck_rise && !wake_done) begin
      wake_q <= wake_q + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      in_dpd_out <= 1'b0;
      rx_enable_out <= 1'b1;
      core_power_out <= 1'b1;
      data_valid_out <= 1'b0;
      ready_out <= 1'b0;
      nop_out <= 1'b0;
      clock_stopped_out <= 1'b0;
    end else begin
      in_dpd_out <= (state_d == LPDCS_DPD);
      // buffers and power off in DPD
      rx_enable_out <= (state_d != LPDCS_DPD);
      core_power_out <= (state_d != LPDCS_DPD);
      if (state_d == LPDCS_DPD_ENTRY) begin
        data_valid_out <= 1'b0;
      end else if (state_q == LPDCS_UNINIT && init_done_in) begin
        data_valid_out <= 1'b1;
      end
      ready_out <= (state_d == LPDCS_ACTIVE) && stable_ok;
      // NOP is flagged only, no state is touched
      // nothing decoded once receivers are off
      nop_out <= ck_rise && nop_valid && (state_d != LPDCS_DPD);
      clock_stopped_out <= idle_full;
    end
  end
endmodule : lpdcs_top
`default_nettype wire

/* File: sim/lpdcs_sva.sv */
// Port assertions for the command watcher
`timescale 1ns/1ns
`default_nettype none
module lpdcs_sva (
  // Clock, reset, pin
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic cke_in,
  // Status
  input wire logic in_dpd_out,
  input wire logic rx_enable_out,
  input wire logic core_power_out,
  input wire logic data_valid_out,
  input wire logic ready_out,
  input wire logic nop_out,
  input wire logic clock_stopped_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_rx_off_dpd: assert property (in_dpd_out |-> !rx_enable_out)
    else $error("receivers on in deep power-down");
  a_power_off_dpd: assert property (in_dpd_out |-> !core_power_out)
    else $error("core power on in deep power-down");
  a_no_nop_dpd: assert property (in_dpd_out |-> !nop_out)
    else $error("command decoded in deep power-down");
  a_data_lost: assert property ($rose(in_dpd_out) |-> !data_valid_out)
    else $error("data still valid after entry");
  a_entry_cke: assert property ($rose(in_dpd_out) |-> !$past(cke_in, 3))
    else $error("entry without cke low");
  a_exit_cke: assert property ($fell(in_dpd_out) |-> $past(cke_in, 3))
    else $error("exit without cke high");
  a_nop_pulse: assert property (nop_out |=> !nop_out)
    else $error("nop flag longer than a cycle");
  a_ready_init: assert property (ready_out |-> data_valid_out)
    else $error("ready before initialization");
  a_ready_clock: assert property ($rose(ready_out) |-> !clock_stopped_out)
    else $error("ready with clock stopped");
endmodule : lpdcs_sva
`default_nettype wire

/* File: sim/lpdcs_ctrl_model.sv */
// Controller model driving clock and command pins
`timescale 1ns/1ns
`default_nettype none
module lpdcs_ctrl_model (
  // Requests
  input wire logic run_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [2:0] ca_in,
  // Pins
  output logic ck_out,
  output logic cke_out,
  output logic cs_n_out,
  output logic [2:0] ca_out
);
  logic [2:0] ca_q;
  initial begin
    ck_out = 1'h0;
    #10;
    forever #200 ck_out = run_in ? ~ck_out : 1'h0;
  end
  initial begin
    cke_out = 1'h1;
    cs_n_out = 1'h1;
    ca_q = 3'h7;
  end
  // pins move away from the sampling edge
  always @(negedge ck_out) begin
    cke_out <= cke_in;
    cs_n_out <= cs_n_in;
    ca_q <= ca_in;
  end
  // Deselected lines show no stale value
  assign ca_out = cs_n_out ? ~ca_q : ca_q;
endmodule : lpdcs_ctrl_model
`default_nettype wire

/* File: sim/lpdcs_top_test.sv */
// Bench for the command watcher
`timescale 1ns/1ns
`default_nettype none
module lpdcs_top_test;
  logic clk_in, reset_in, init_done_in, run, ck, cke, cs_n, kr, cr;
  logic in_dpd, rx_en, pwr, dv, ready, nop, stopped;
  logic [2:0] ca, ar;
  logic [5:0] tbl [6] = '{6'h3F, 6'h2F, 6'h26, 6'h1E, 6'h1F, 6'h3E};
  int err_total = 0;
  int total_checks = 0;
  int nops = 0;
  int dn;
  lpdcs_ctrl_model i_lpdcs_ctrl_model (.run_in(run), .cke_in(kr),
    .cs_n_in(cr), .ca_in(ar), .ck_out(ck), .cke_out(cke),
    .cs_n_out(cs_n), .ca_out(ca));
  lpdcs_top i_lpdcs_top (.clk_in(clk_in), .reset_in(reset_in), .ck_in(ck),
    .cke_in(cke), .cs_n_in(cs_n), .ca_in(ca), .init_done_in(init_done_in),
    .in_dpd_out(in_dpd), .rx_enable_out(rx_en), .core_power_out(pwr),
    .data_valid_out(dv), .ready_out(ready), .nop_out(nop),
    .clock_stopped_out(stopped));
  initial begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (nop === 1'h1) nops <= nops + 1;
  task chk(string n, logic e, logic s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask : chk
  task tally_and_finish;
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Nops seen at the last edge end up in dn
  task cmd(logic k, logic c, logic [2:0] a, int n);
    {kr, cr, ar} = {k, c, a};
    repeat (n) begin
      @(negedge ck);
      @(posedge ck);
      dn = nops;
    end
    // Back before the next fall, so no command is sent twice
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    dn = nops - dn;
  endtask : cmd
  task t_init;
    @(posedge clk_in) #5 init_done_in = 1'h1;
    @(posedge clk_in) #5 init_done_in = 1'h0;
    repeat (800) if (ready !== 1'h1) @(posedge clk_in);
    chk("ready", 1'h1, ready);
    chk("data_valid", 1'h1, dv);
    if (ready !== 1'h1) tally_and_finish();
  endtask : t_init
  task t_nop;
    foreach (tbl[i]) begin
      cmd(tbl[i][5], tbl[i][4], tbl[i][3:1], 1);
      chk("nop", tbl[i][0], dn == 1);
    end
    chk("dpd_on_cke_high", 1'h0, in_dpd);
    chk("ready_kept", 1'h1, ready);
  endtask : t_nop
  task t_dpd;
    cmd(1'h0, 1'h0, 3'h3, 1);
    chk("rx_in_cpded", 1'h1, rx_en);
    cmd(1'h0, 1'h1, 3'h7, 2);
    chk("in_dpd", 1'h1, in_dpd);
    chk("rx_enable", 1'h0, rx_en);
    chk("core_power", 1'h0, pwr);
    chk("data_valid", 1'h0, dv);
    cmd(1'h0, 1'h1, 3'h7, 3);
    chk("nop_in_dpd", 1'h0, dn != 0);
    cmd(1'h1, 1'h1, 3'h7, 1);
    chk("dpd_exit", 1'h0, in_dpd);
    chk("ready_uninit", 1'h0, ready);
    t_init();
  endtask : t_dpd
  task t_reset;
    cmd(1'h0, 1'h0, 3'h3, 1);
    cmd(1'h0, 1'h1, 3'h7, 2);
    @(posedge clk_in) #5 reset_in = 1'h1;
    cmd(1'h1, 1'h1, 3'h7, 2);
    chk("reset_in_dpd", 1'h0, in_dpd);
    chk("reset_rx", 1'h1, rx_en);
    chk("reset_power", 1'h1, pwr);
    chk("reset_data", 1'h0, dv);
    chk("reset_ready", 1'h0, ready);
    @(posedge clk_in) #5 reset_in = 1'h0;
    t_init();
  endtask : t_reset
  task t_stop(logic k);
    // cs high, original clock two edges before the stop
    cmd(k, 1'h1, 3'h7, 2);
    run = 1'h0;
    repeat (40) @(posedge clk_in);
    chk("clock_stopped", 1'h1, stopped);
    chk("ready_stopped", 1'h0, ready);
    run = 1'h1;
    cmd(k, 1'h1, 3'h7, 2);
    chk("clock_running", 1'h0, stopped);
    // period unchanged, so no mode writes follow
    cmd(1'h1, 1'h1, 3'h7, 2);
    chk("ready_early", 1'h0, ready);
    t_init();
  endtask : t_stop
  // Run limit: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {reset_in, init_done_in, run, kr, cr, ar} = 8'hBF;
    repeat (16) @(posedge clk_in);
    #5 reset_in = 1'h0;
    t_init();
    t_nop();
    t_dpd();
    t_reset();
    t_stop(1'h1);
    t_stop(1'h0);
    tally_and_finish();
  end
endmodule : lpdcs_top_test
bind lpdcs_top lpdcs_sva i_lpdcs_sva (.*);
`default_nettype wire
